//--- afe_pkg.sv
// Purpose: Shared constants and carrier types for the analog front end control block
// Assumes: 8-bit registers in the low byte of a 32-bit APB word
// Notes:   Byte address of a register is four times its index

package afe_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam int AFE_ADDR_W = 12;
  localparam logic [AFE_ADDR_W-1:0] AFE_IDX_AMP_MODE = 12'h0090;
  localparam logic [AFE_ADDR_W-1:0] AFE_IDX_CHOP_SEL = 12'h0092;
  localparam logic [AFE_ADDR_W-1:0] AFE_IDX_SUPPLY = 12'h0095;
  localparam logic [AFE_ADDR_W-1:0] AFE_ADR_AMP_MODE = AFE_IDX_AMP_MODE << 2;
  localparam logic [AFE_ADDR_W-1:0] AFE_ADR_CHOP_SEL = AFE_IDX_CHOP_SEL << 2;
  localparam logic [AFE_ADDR_W-1:0] AFE_ADR_SUPPLY = AFE_IDX_SUPPLY << 2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AFE_AMP_EN_BIT = 0;
  localparam int AFE_GAIN_LSB = 1;
  localparam int AFE_LFQ_LSB = 4;
  localparam int AFE_BGR_BIT = 6;
  localparam int AFE_CHP_BIT = 7;
  localparam int AFE_CM_SEL_BIT = 3;
  localparam int AFE_EXC_EN_BIT = 4;
  localparam int AFE_EXC_SEL_BIT = 5;
  localparam int AFE_REG_EN_BIT = 6;
  localparam int AFE_CM_EN_BIT = 7;
  localparam int AFE_SUPPLY_LSB = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] AFE_AMP_MODE_RST = 8'h00be;
  localparam logic [2:0] AFE_CHOP_SEL_RST = 3'h0;
  localparam logic [4:0] AFE_SUPPLY_RST = 5'h00;

  // ----------------------------------------------------------------
  // Gain codes and chopper clock division
  // ----------------------------------------------------------------
  localparam logic [2:0] AFE_GAIN_X16 = 3'h0;
  localparam logic [2:0] AFE_GAIN_X32 = 3'h1;
  localparam logic [2:0] AFE_GAIN_X64 = 3'h2;
  localparam logic [2:0] AFE_GAIN_X128 = 3'h3;
  localparam logic [2:0] AFE_GAIN_X1 = 3'h7;
  localparam int AFE_CHOP_DIV_BASE = 32;
  localparam int AFE_CHOP_CNT_W = 11;
  localparam logic [AFE_CHOP_CNT_W-1:0] AFE_CHOP_HALF_BASE =
    AFE_CHOP_CNT_W'(AFE_CHOP_DIV_BASE / 2);
  localparam int AFE_CLK_HZ = 20_000_000;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic regulator_enable;
    logic common_mode_enable;
    logic excitation_enable;
    logic excitation_level_select;
    logic common_mode_level_select;
    logic amplifier_enable;
    logic [2:0] gain_code;
    logic gain_valid;
    logic [2:0] gain_shift;
    logic [1:0] chopper_low_freq_field;
    logic bandgap_enable;
    logic chopper_enable;
  } afe_analog_t;

endpackage

//--- afe_chop_div.sv
// Purpose: Chopper clock divider, input clock over base times two to the select
// Assumes: Select may change at any time; it takes effect at the next toggle
// Notes:   Output is held low and the count cleared while not running
`timescale 1ns/10ps

module afe_chop_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic run,
  input wire logic [2:0] div_sel,
  output logic chopper_clk
);
  import afe_pkg::*;

  typedef struct packed {
    logic [AFE_CHOP_CNT_W-1:0] count;
    logic [2:0] sel;
    logic clk_out;
  } afe_div_state_t;

  afe_div_state_t st;
  afe_div_state_t next_st;
  logic [AFE_CHOP_CNT_W-1:0] half_last;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // At the largest select the shift wraps to zero, so the last count is all ones
    half_last = (AFE_CHOP_HALF_BASE << st.sel) - AFE_CHOP_CNT_W'(1);
    if (!run) begin
      next_st.count = '0;
      next_st.sel = div_sel;
      next_st.clk_out = 1'b0;
    end else if (st.count >= half_last) begin
      // New select taken only at a toggle, so a change never makes a runt half period
      next_st.count = '0;
      next_st.sel = div_sel;
      next_st.clk_out = ~st.clk_out;
    end else begin
      next_st.count = st.count + AFE_CHOP_CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (pclk_en) begin
      st <= next_st;
    end
  end

  assign chopper_clk = st.clk_out;

endmodule

//--- afe_control.sv
// Purpose: Register file and control outputs for the analog front end
// Assumes: APB slave, no wait states, pready in the first access cycle, pclk at 20 MHz
// Notes:   Analog circuits are only steered; their level outputs are registered
//
// Contract
// - Supply bit 6 turns the regulator and its output on, clear turns off
// - Supply bit 7 turns the common-mode output on, clear turns it off
// - Supply bit 4 turns the excitation output on, clear turns it off
// - Level selects at bits 5 and 3 pick the only levels at zero
// - Amplifier mode bit 0 switches the gain amplifier on and off
// - Gain code in bits 3..1 selects gain 16, 32, 64, 128 or 1
// - Amplifier mode bit 6 switches the band-gap reference
// - Amplifier mode bit 7 runs or stops the chopper
// - Chopper clock is the input clock over 32 times two to the select
// - Divider select sits in bits 2..0, write-only, resets to zero
// - Amplifier mode resets with chopper on, field 11, gain 111
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps

module afe_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [afe_pkg::AFE_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output afe_pkg::afe_analog_t analog,
  output logic chopper_clk
);
  import afe_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] amp_mode;
    logic [2:0] div_sel;
    logic [4:0] supply;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    afe_analog_t ana;
  } afe_state_t;

  afe_state_t st;
  afe_state_t next_st;

  logic setup_phase;
  logic access_done;
  logic hit_amp;
  logic hit_chop;
  logic hit_supply;
  logic hit_any;
  logic wr_low_byte;

  // ----------------------------------------------------------------
  // Gain decode
  // ----------------------------------------------------------------
  // Returns {valid, log2 of gain}; reserved codes report invalid
  function automatic logic [3:0] afe_gain_decode(input logic [2:0] code);
    logic [3:0] res;
    res = 4'h0;
    unique case (code)
      AFE_GAIN_X16: begin
        res = {1'b1, 3'h4};
      end
      AFE_GAIN_X32: begin
        res = {1'b1, 3'h5};
      end
      AFE_GAIN_X64: begin
        res = {1'b1, 3'h6};
      end
      AFE_GAIN_X128: begin
        res = {1'b1, 3'h7};
      end
      AFE_GAIN_X1: begin
        res = {1'b1, 3'h0};
      end
      default: begin
        res = 4'h0;
      end
    endcase
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always_comb begin
    setup_phase = psel & ~penable;
    access_done = psel & penable & st.pready;
    hit_amp = (paddr == AFE_ADR_AMP_MODE);
    hit_chop = (paddr == AFE_ADR_CHOP_SEL);
    hit_supply = (paddr == AFE_ADR_SUPPLY);
    hit_any = hit_amp | hit_chop | hit_supply;
    // Registers are one byte wide, so only lane 0 carries write data
    wr_low_byte = access_done & pwrite & pstrb[0];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] gdec;
    gdec = 4'h0;
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;

    // Setup phase: prepare the answer for the single access cycle
    if (setup_phase) begin
      next_st.pready = 1'b1;
      next_st.pslverr = ~hit_any;
      next_st.prdata = 32'h0000_0000;
      if (!pwrite) begin
        if (hit_amp) begin
          next_st.prdata[7:0] = st.amp_mode;
        end else if (hit_supply) begin
          next_st.prdata[7:AFE_SUPPLY_LSB] = st.supply;
        end
        // Divider select is write-only and reads as zero
      end
    end

    // Writes take effect only at the completing edge
    if (wr_low_byte) begin
      if (hit_amp) begin
        next_st.amp_mode = pwdata[7:0];
      end
      if (hit_chop) begin
        next_st.div_sel = pwdata[2:0];
      end
      if (hit_supply) begin
        next_st.supply = pwdata[7:AFE_SUPPLY_LSB];
      end
    end

    // Control levels follow the registers on the same edge as the write
    next_st.ana.regulator_enable =
      next_st.supply[AFE_REG_EN_BIT-AFE_SUPPLY_LSB];
    next_st.ana.common_mode_enable =
      next_st.supply[AFE_CM_EN_BIT-AFE_SUPPLY_LSB];
    next_st.ana.excitation_enable =
      next_st.supply[AFE_EXC_EN_BIT-AFE_SUPPLY_LSB];
    // Reserved value 1 is passed through; the analog side treats 0 as the level
    next_st.ana.excitation_level_select =
      next_st.supply[AFE_EXC_SEL_BIT-AFE_SUPPLY_LSB];
    next_st.ana.common_mode_level_select =
      next_st.supply[AFE_CM_SEL_BIT-AFE_SUPPLY_LSB];
    next_st.ana.amplifier_enable = next_st.amp_mode[AFE_AMP_EN_BIT];
    next_st.ana.gain_code = next_st.amp_mode[AFE_GAIN_LSB+:3];
    gdec = afe_gain_decode(next_st.amp_mode[AFE_GAIN_LSB+:3]);
    next_st.ana.gain_valid = gdec[3];
    next_st.ana.gain_shift = gdec[2:0];
    next_st.ana.chopper_low_freq_field = next_st.amp_mode[AFE_LFQ_LSB+:2];
    next_st.ana.bandgap_enable = next_st.amp_mode[AFE_BGR_BIT];
    next_st.ana.chopper_enable = next_st.amp_mode[AFE_CHP_BIT];
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.amp_mode <= AFE_AMP_MODE_RST;
      st.div_sel <= AFE_CHOP_SEL_RST;
      st.supply <= AFE_SUPPLY_RST;
      st.ana.gain_code <= AFE_GAIN_X1;
      st.ana.gain_valid <= 1'b1;
      st.ana.gain_shift <= 3'h0;
      st.ana.chopper_low_freq_field <= 2'h3;
      st.ana.chopper_enable <= 1'b1;
    end else if (pclk_en) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Chopper clock
  // ----------------------------------------------------------------
  // Divider idles while chopping is off, which saves toggling power
  afe_chop_div u_chop_div (
    .pclk(pclk),
    .presetn(presetn),
    .pclk_en(pclk_en),
    .run(st.ana.chopper_enable),
    .div_sel(st.div_sel),
    .chopper_clk(chopper_clk)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign analog = st.ana;

endmodule

//--- afe_monitor.sv
// Purpose: Port-level checks of the analog front end control block
// Assumes: pclk_en high while these relations are judged
// Notes:   Bound into afe_control; sees its ports only
`timescale 1ns/10ps

module afe_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [afe_pkg::AFE_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire afe_pkg::afe_analog_t analog,
  input wire logic chopper_clk
);
  import afe_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_ok;
  assign wr_ok = psel && penable && pready && pwrite && pclk_en && pstrb[0];
  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  ready_after_setup_a: assert property (psel && !penable && pclk_en |=> pready)
    else $error("no answer after setup");
  ready_one_cycle_a: assert property (pready && pclk_en |=> !pready)
    else $error("ready held too long");
  err_needs_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  upper_read_zero_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  chop_read_zero_a: assert property (
    pready && !pwrite && paddr == AFE_ADR_CHOP_SEL |-> prdata == 32'h0000_0000)
    else $error("divider select readable");
  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  supply_write_a: assert property (
    wr_ok && paddr == AFE_ADR_SUPPLY |=> {analog.common_mode_enable, analog.regulator_enable,
    analog.excitation_level_select, analog.excitation_enable,
    analog.common_mode_level_select} == $past(pwdata[7:3]))
    else $error("supply outputs not updated");
  amp_write_a: assert property (
    wr_ok && paddr == AFE_ADR_AMP_MODE |=> {analog.chopper_enable, analog.bandgap_enable,
    analog.chopper_low_freq_field, analog.gain_code,
    analog.amplifier_enable} == $past(pwdata[7:0]))
    else $error("amplifier outputs not updated");
  gain_shift_a: assert property (
    !analog.gain_code[2] |-> analog.gain_valid && analog.gain_shift == {1'b1, analog.gain_code[1:0]})
    else $error("gain decode wrong");
  unity_gain_a: assert property (
    analog.gain_code == 3'h7 |-> analog.gain_valid && analog.gain_shift == 3'h0)
    else $error("unity gain decode wrong");
  reserved_gain_a: assert property (
    analog.gain_code[2] && analog.gain_code != 3'h7 |-> !analog.gain_valid &&
    analog.gain_shift == 3'h0)
    else $error("reserved gain reported valid");
  chop_idle_a: assert property (!analog.chopper_enable [*2] |-> !chopper_clk)
    else $error("chopper clock runs while off");
  chop_half_a: assert property ($rose(chopper_clk) |->
    (chopper_clk || !analog.chopper_enable) [*8])
    else $error("chopper half period too short");
endmodule

bind afe_control afe_monitor u_mon (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .analog(analog),
  .chopper_clk(chopper_clk));

//--- tb_top.sv
// Purpose: Self-checking bench for the analog front end control block
// Assumes: pclk_en tied high; one APB master in this bench
// Notes:   Divider periods are measured rise to rise in pclk edges
`timescale 1ns/10ps

module tb_top;
  import afe_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [AFE_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'h1;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  afe_analog_t analog;
  logic chopper_clk;
  int num_errors = 0;
  int num_checks = 0;
  always #25 pclk = ~pclk;
  afe_control u_dut (.pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .analog(analog),
    .chopper_clk(chopper_clk));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input afe_analog_t got, input afe_analog_t exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: outputs %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [AFE_ADDR_W-1:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [AFE_ADDR_W-1:0] a, input logic [7:0] d, input logic e);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, {24'h00_0000, d}, rd, err);
    chk_reg({31'h0000_0000, err}, {31'h0000_0000, e});
  endtask
  task automatic rd_chk(input logic [AFE_ADDR_W-1:0] a, input logic [7:0] d, input logic e);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    chk_reg(rd, {24'h00_0000, d});
    chk_reg({31'h0000_0000, err}, {31'h0000_0000, e});
  endtask
  // Expected outputs follow the register bits, never the design's decode
  function automatic afe_analog_t exp_an(input logic [7:0] s, input logic [7:0] a);
    afe_analog_t e;
    e.regulator_enable = s[6];
    e.common_mode_enable = s[7];
    e.excitation_enable = s[4];
    e.excitation_level_select = s[5];
    e.common_mode_level_select = s[3];
    e.amplifier_enable = a[0];
    e.gain_code = a[3:1];
    e.gain_valid = (a[3:1] < 3'h4) || (a[3:1] == 3'h7);
    e.gain_shift = a[3] ? 3'h0 : {1'b1, a[2:1]};
    e.chopper_low_freq_field = a[5:4];
    e.bandgap_enable = a[6];
    e.chopper_enable = a[7];
    return e;
  endfunction
  task automatic wait_rise(output int n);
    n = 0;
    while (chopper_clk !== 1'b0) begin
      @(posedge pclk);
      n++;
    end
    while (chopper_clk !== 1'b1) begin
      @(posedge pclk);
      n++;
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    int n;
    rd_chk(AFE_ADR_AMP_MODE, 8'hbe, 1'b0);
    rd_chk(AFE_ADR_CHOP_SEL, 8'h00, 1'b0);
    rd_chk(AFE_ADR_SUPPLY, 8'h00, 1'b0);
    chk_out(analog, exp_an(8'h00, 8'hbe));
    repeat (2) wait_rise(n);
    chk_reg(32'(n), 32'h0000_0020);
    $display("test reset done");
  endtask
  task automatic t_supply();
    logic [7:0] s;
    wr(AFE_ADR_AMP_MODE, 8'hfe, 1'b0);
    for (int i = 3; i < 8; i++) begin
      s = 8'h01 << i;
      wr(AFE_ADR_SUPPLY, s, 1'b0);
      rd_chk(AFE_ADR_SUPPLY, s, 1'b0);
      chk_out(analog, exp_an(s, 8'hfe));
    end
    wr(AFE_ADR_SUPPLY, 8'hff, 1'b0);
    rd_chk(AFE_ADR_SUPPLY, 8'hf8, 1'b0);
    pstrb <= 4'h0;
    wr(AFE_ADR_SUPPLY, 8'h00, 1'b0);
    pstrb <= 4'h1;
    rd_chk(AFE_ADR_SUPPLY, 8'hf8, 1'b0);
    $display("test supply done");
  endtask
  task automatic t_amp();
    logic [7:0] a;
    logic [2:0] g;
    for (int i = 0; i < 8; i++) begin
      g = 3'(i);
      a = {g[1], 1'b1, 2'b11, g, g[2]};
      wr(AFE_ADR_AMP_MODE, a, 1'b0);
      rd_chk(AFE_ADR_AMP_MODE, a, 1'b0);
      chk_out(analog, exp_an(8'hf8, a));
    end
    $display("test amplifier done");
  endtask
  task automatic t_unmapped();
    wr(12'h0244, 8'hff, 1'b1);
    rd_chk(12'h0244, 8'h00, 1'b1);
    rd_chk(12'h0241, 8'h00, 1'b1);
    chk_out(analog, exp_an(8'hf8, 8'hff));
    wr(AFE_ADR_CHOP_SEL, 8'h05, 1'b0);
    rd_chk(AFE_ADR_CHOP_SEL, 8'h00, 1'b0);
    $display("test unmapped done");
  endtask
  task automatic t_chop(input logic [2:0] sel);
    int n;
    wr(AFE_ADR_CHOP_SEL, {5'h00, sel}, 1'b0);
    repeat (3) wait_rise(n);
    chk_reg(32'(n), 32'h0000_0020 << sel);
    $display("test divider %0d done", sel);
  endtask
  task automatic t_off();
    logic hi;
    hi = 1'b0;
    wr(AFE_ADR_AMP_MODE, 8'h7e, 1'b0);
    repeat (2) @(posedge pclk);
    chk_out(analog, exp_an(8'hf8, 8'h7e));
    repeat (64) begin
      @(posedge pclk);
      hi = hi | (chopper_clk !== 1'b0);
    end
    chk_reg({31'h0000_0000, hi}, 32'h0000_0000);
    $display("test chopper off done");
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    $display("ERROR at %0t: timeout got %h expected %h", $time, 1'b1, 1'b0);
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_supply();
    t_amp();
    t_unmapped();
    t_chop(3'h0);
    t_chop(3'h4);
    t_off();
    wrap_up();
  end
endmodule
